/* File: bench/bbrc_stage_model.sv */
// power stage model: the sense comparators seen by the core
`timescale 1ns/100ps
module bbrc_stage_model import bbrc_pkg::*; (
    input wire logic sys_clk_i,
    input wire bbrc_switch_t switches_i,
    input wire logic short_i,
    input wire logic reverse_i,
    output logic pos_cmp_o,
    output logic neg_cmp_o
);
    // a hard short keeps the comparator tripped even with the switches off,
    // so a retry out of fast stop really fails; one clock of comparator delay
    always_ff @(posedge sys_clk_i) begin
        pos_cmp_o <= short_i;
        // reverse current only flows while some switch conducts
        neg_cmp_o <= reverse_i & (switches_i != '0);
    end
endmodule

/* File: bench/tb_top.sv */
// directed bench for the ramp and current limit core
`timescale 1ns/100ps
module tb_top import bbrc_pkg::*; ;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    bbrc_reg_req_t req = '0;
    logic en = 1'b0, boost = 1'b0, pre = 1'b0, av = 1'b0, asel = 1'b0;
    logic short = 1'b0, rev = 1'b0, pos_cmp, neg_cmp, fs, lt, bad;
    logic [6:0] acode = 7'h00;
    logic [7:0] rdata;
    logic [8:0] ref_v, d, r;
    logic [1:0] pl, nl;
    bbrc_switch_t sw;
    int err_count = 0;
    int n_compared = 0;
    int g;
    int exp_gap [4] = '{167, 84, 42, 21};
    int per_exp [8] = '{16, 66, 33, 22, 13, 11, 8, 16};

    // 10 MHz clock
    always #50 sys_clk_i = ~sys_clk_i;

    bbrc_core #(.ILIM_TIMEOUT_CYC(200), .FAST_STOP_CYC(300)) uut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .en_pin_i(en), .mode_boost_i(boost),
        .pwm_duty_i(8'h80), .pos_cmp_i(pos_cmp), .neg_cmp_i(neg_cmp),
        .prebias_i(pre), .adc_valid_i(av), .adc_sel_i(asel),
        .adc_code_i(acode), .switches_o(sw), .dac_ref_o(ref_v),
        .pos_peak_limit_o(pl), .neg_peak_limit_o(nl), .fast_stop_o(fs),
        .latched_o(lt));

    bbrc_stage_model stage (.sys_clk_i(sys_clk_i), .switches_i(sw),
        .short_i(short), .reverse_i(rev), .pos_cmp_o(pos_cmp),
        .neg_cmp_o(neg_cmp));

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] got);
        n_compared++;
        if (got !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        req <= '{1'b1, 1'b0, a, v};
        @(posedge sys_clk_i);
        req <= '0;
    endtask

    // read data stands from the cycle after the request until the next read
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input string nm);
        @(posedge sys_clk_i);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk_i);
        req <= '0;
        @(posedge sys_clk_i);
        #1 chk(nm, {8'h00, e}, {8'h00, rdata});
    endtask

    // waits for one reference step, then times the next one
    task automatic step_gap(output int n, output logic [8:0] dv);
        logic [8:0] r0;
        int k;
        // start off the edge so a step landing on it is not missed
        #1 k = 0;
        r0 = ref_v;
        while (ref_v === r0 && k < 400) begin
            @(posedge sys_clk_i);
            #1 k++;
        end
        r0 = ref_v;
        n = 0;
        while (ref_v === r0 && n < 400) begin
            @(posedge sys_clk_i);
            #1 n++;
        end
        dv = ref_v - r0;
    endtask

    task automatic wait_lvl(input logic v, inout int n);
        while (sw.input_high_switch !== v && n < 300) begin
            @(posedge sys_clk_i);
            #1 n++;
        end
    endtask

    // clocks between two rises of the input high switch
    task automatic rise_gap(output int n);
        n = 0;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        n = 0;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
    endtask

    // switches that must stay fixed in the present mode over many clocks
    task automatic scan(input int n, output logic b);
        b = 1'b0;
        repeat (n) begin
            @(posedge sys_clk_i);
            #1 b |= boost ? (!sw.input_high_switch | sw.input_low_switch)
                : (!sw.output_rectify_switch | sw.output_low_switch);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        cyc(8);
        rst_i <= 1'b0;
        en <= 1'b1;
        #1 chk("limit rst", 16'h0000, 16'({pl, nl, ref_v}));
        rd(REG_CONFIG, CONFIG_RST, "config");
        rd(REG_LIMITS, LIMITS_RST, "limits");
        rd(REG_PROFILE, PROFILE_RST, "profile");
        rd(8'h07, 8'h00, "unmapped");
        for (int c = 0; c < 4; c++) begin
            wr(REG_LIMITS, 8'((c << 2) | (c << 4)));
            cyc(2);
            #1 chk("pos code", 16'(c), 16'(pl));
            chk("neg code", 16'(c), 16'(nl));
        end
        wr(REG_PROFILE, 8'h0a);
        for (int s = 0; s < 4; s++) begin
            wr(REG_ENABLE, 8'h00);
            wr(REG_LIMITS, 8'(s));
            wr(REG_ENABLE, 8'h01);
            step_gap(g, d);
            chk("step gap", 16'(exp_gap[s]), 16'(g));
            chk("step size", 16'h0002, 16'(d));
        end
        cyc(250);
        #1 chk("ramp end", 16'h0014, 16'(ref_v));
        @(posedge sys_clk_i);
        rev <= 1'b1;
        wr(REG_PROFILE, 8'h05);
        cyc(60);
        #1 chk("neg hold", 16'h0014, 16'(ref_v));
        chk("rect off", 16'h0000, 16'(sw.output_rectify_switch));
        @(posedge sys_clk_i);
        rev <= 1'b0;
        cyc(20);
        #1 chk("rect back", 16'h1, 16'(sw.output_rectify_switch));
        step_gap(g, d);
        chk("down step", 16'h01fe, 16'(d));
        cyc(120);
        scan(32, bad);
        chk("buck fixed", 16'h0000, 16'(bad));
        @(posedge sys_clk_i);
        boost <= 1'b1;
        scan(32, bad);
        chk("boost fixed", 16'h0000, 16'(bad));
        @(posedge sys_clk_i);
        boost <= 1'b0;
        wr(REG_CONFIG, 8'h10);
        wr(REG_PROFILE, 8'h0a);
        step_gap(g, d);
        chk("half gap", 16'h000b, 16'(g));
        chk("half size", 16'h0001, 16'(d));
        cyc(150);
        #1 chk("half end", 16'h0015, 16'(ref_v));
        for (int i = 0; i < 8; i++) begin
            wr(REG_CONFIG, 8'(i));
            rd(REG_CONFIG, 8'(i), "freq code");
            rise_gap(g);
            rise_gap(g);
            chk("period", 16'(per_exp[i]), 16'(g));
        end
        @(posedge sys_clk_i);
        av <= 1'b1;
        acode <= 7'h55;
        @(posedge sys_clk_i);
        asel <= 1'b1;
        acode <= 7'h2a;
        @(posedge sys_clk_i);
        av <= 1'b0;
        rd(REG_SENSE_A, 8'h55, "sense a");
        rd(REG_SENSE_B, 8'h2a, "sense b");
        wr(REG_ENABLE, 8'h00);
        cyc(100); // host pause before a new soft start
        pre <= 1'b1;
        wr(REG_ENABLE, 8'h01);
        bad = 1'b0;
        repeat (40) begin
            @(posedge sys_clk_i);
            #1 bad |= sw.input_low_switch;
        end
        chk("non sync", 16'h0000, 16'(bad));
        @(posedge sys_clk_i);
        pre <= 1'b0;
        wr(REG_PROFILE, 8'h64);
        cyc(30);
        short <= 1'b1;
        cyc(2);
        #1 r = ref_v;
        chk("s1 off", 16'h0000, 16'(sw.input_high_switch));
        cyc(100);
        #1 chk("pos hold", 16'(r), 16'(ref_v));
        chk("no stop", 16'h0000, 16'(fs));
        cyc(110);
        #1 chk("fast stop", 16'h0001, 16'(fs));
        chk("all off", 16'h0000, 16'(sw));
        @(posedge sys_clk_i);
        short <= 1'b0;
        cyc(300);
        #1 chk("restart", 16'h0000, 16'(fs));
        step_gap(g, d);
        chk("soft start", 16'h0002, 16'(d));
        @(posedge sys_clk_i);
        short <= 1'b1;
        cyc(1900);
        #1 chk("latched", 16'h0001, 16'(lt));
        chk("latch off", 16'h0000, 16'(sw));
        rd(REG_STATUS, 8'h07, "status");
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        short <= 1'b0;
        cyc(2);
        rst_i <= 1'b0;
        cyc(1);
        #1 chk("unlatch", 16'h0000, 16'({lt, ref_v}));
        wr(REG_ENABLE, 8'h01);
        short <= 1'b1;
        cyc(150);
        wr(REG_ENABLE, 8'h00);
        wr(REG_ENABLE, 8'h01);
        cyc(150);
        #1 chk("timeout restart", 16'h0000, 16'(fs));
        complete_run();
    end

    // watchdog: the tests need under a third of this span
    initial begin
        cyc(20000);
        err_count++;
        complete_run();
    end
endmodule

/* File: hw/bbrc_core.sv */
// buck-boost reference ramp, switch drive and peak current limit core
// Overview of operation
// - reset selects slowest ramp, 0.6 mV/us; no slower code exists.
// - ramp applies to start-up, profile change and any target change.
// - 9-bit reference moves in 10 mV or 5 mV steps toward target.
// - ramp rate is set by the step clock period.
// - slew codes 0..3 give 0.6, 1.2, 2.4, 4.8 mV/us.
// - upward ramp pauses while the positive limit is tripped.
// - downward ramp pauses while the negative limit is tripped.
// - pre-bias at start runs the whole soft start non-synchronously.
// - 3-bit code selects 600,150,300,450,750,900,1200 kHz; 111 reserved.
// - frequency defaults 600 kHz and may change while running.
// - either sense output is stored as a 7-bit readable value.
// - positive trip turns input high switch off; re-armed each cycle.
// - positive limiting lasting 2 ms enters fast stop.
// - fast stop holds all switches off 10 ms, then soft starts.
// - prolonged overcurrent latches shutdown until supply is cycled.
// - positive threshold codes 38, 23, 11, 70 mV; default 38.
// - negative threshold codes -40, -25, -15, 0 mV; default -40.
// - negative trip turns rectifier off for rest of its cycle.
// - in buck the rectifier returns when input low on-period ends.
// - buck alternates input switches; boost alternates output switches.
// - target comes from profile register with selectable 5 mV lsb.
`timescale 1ns/100ps
module bbrc_core import bbrc_pkg::*; #(
    parameter int ILIM_TIMEOUT_CYC = ILIM_TIMEOUT_CYC_DEF,
    parameter int FAST_STOP_CYC = FAST_STOP_CYC_DEF
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire bbrc_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire logic en_pin_i,
    input wire logic mode_boost_i,
    input wire logic [7:0] pwm_duty_i,
    input wire logic pos_cmp_i,
    input wire logic neg_cmp_i,
    input wire logic prebias_i,
    input wire logic adc_valid_i,
    input wire logic adc_sel_i,
    input wire logic [6:0] adc_code_i,
    output bbrc_switch_t switches_o,
    output logic [8:0] dac_ref_o,
    output logic [1:0] pos_peak_limit_o,
    output logic [1:0] neg_peak_limit_o,
    output logic fast_stop_o,
    output logic latched_o
);
    logic [7:0] en_q, en_d, prof_q, prof_d, lim_q, lim_d, cfg_q, cfg_d;
    logic [6:0] sense_a_q, sense_a_d, sense_b_q, sense_b_d;
    logic [7:0] rdata_q, rdata_d;
    bbrc_state_t state_q, state_d;
    logic [8:0] ref_q, ref_d, tgt;
    logic [16:0] lim_cnt_q, lim_cnt_d, hold_cnt_q, hold_cnt_d;
    logic [2:0] retry_q, retry_d;
    logic nonsync_q, nonsync_d, run_q, run_d, run, step_tick;
    logic [6:0] per_q, per_d, cyc_q, cyc_d;
    logic pos_trip_q, pos_trip_d, prev_trip_q, prev_trip_d;
    logic neg_off_q, neg_off_d, cyc_start, on_win, limiting;
    logic [1:0] slew;
    logic half;
    bbrc_switch_t sw;

    assign slew = lim_q[LIM_SLEW_LSB +: 2];
    assign half = cfg_q[CFG_HALF_BIT];
    assign tgt = {prof_q, half}; // 5 mV units
    assign run = en_pin_i & en_q[0];

    // register writes, sense capture and registered read data
    always_comb begin
        en_d = en_q;
        prof_d = prof_q;
        lim_d = lim_q;
        cfg_d = cfg_q;
        sense_a_d = sense_a_q;
        sense_b_d = sense_b_q;
        rdata_d = rdata_q;
        if (adc_valid_i && !adc_sel_i) begin
            sense_a_d = adc_code_i;
        end
        if (adc_valid_i && adc_sel_i) begin
            sense_b_d = adc_code_i;
        end
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                REG_ENABLE: en_d = {7'h00, reg_req_i.wdata[0]};
                REG_PROFILE: prof_d = reg_req_i.wdata;
                REG_LIMITS: lim_d = {2'h0, reg_req_i.wdata[5:0]};
                REG_CONFIG: cfg_d = {3'h0, reg_req_i.wdata[4:0]};
                default: ;
            endcase
        end
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                REG_ENABLE: rdata_d = en_q;
                REG_PROFILE: rdata_d = prof_q;
                REG_LIMITS: rdata_d = lim_q;
                REG_CONFIG: rdata_d = cfg_q;
                REG_SENSE_A: rdata_d = {1'b0, sense_a_q};
                REG_SENSE_B: rdata_d = {1'b0, sense_b_q};
                REG_STATUS: rdata_d = {3'h0, nonsync_q, limiting,
                                       ref_q != tgt, state_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // slew field resets to code 0, the slowest ramp
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            en_q <= ENABLE_RST;
            prof_q <= PROFILE_RST;
            lim_q <= LIMITS_RST;
            cfg_q <= CONFIG_RST;
            sense_a_q <= 7'h00;
            sense_b_q <= 7'h00;
            rdata_q <= 8'h00;
        end else begin
            en_q <= en_d;
            prof_q <= prof_d;
            lim_q <= lim_d;
            cfg_q <= cfg_d;
            sense_a_q <= sense_a_d;
            sense_b_q <= sense_b_d;
            rdata_q <= rdata_d;
        end
    end

    bbrc_step_gen u_step (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .run_i(state_q == ST_RUN),
        .slew_i(slew),
        .half_i(half),
        .tick_o(step_tick)
    );

    // switching cycle timer; a new period only takes effect at a cycle
    // boundary so an on-the-fly change never cuts a pulse short
    always_comb begin
        cyc_start = (cyc_q >= per_q - 7'h01);
        cyc_d = cyc_start ? 7'h00 : cyc_q + 7'h01;
        per_d = cyc_start ?
            switch_period(cfg_q[CFG_FREQ_LSB +: 3]) : per_q;
        on_win = ({1'b0, cyc_q, 8'h00} < 16'(pwm_duty_i * per_q));
        // trip flags re-arm at each cycle start; a trip in that cycle wins
        pos_trip_d = pos_trip_q;
        neg_off_d = neg_off_q;
        prev_trip_d = prev_trip_q;
        if (cyc_start) begin
            pos_trip_d = 1'b0;
            neg_off_d = 1'b0;
            prev_trip_d = pos_trip_q;
        end
        if (state_q != ST_RUN) begin
            pos_trip_d = 1'b0;
            neg_off_d = 1'b0;
            prev_trip_d = 1'b0;
        end else begin
            if (pos_cmp_i) begin
                pos_trip_d = 1'b1;
            end
            if (neg_cmp_i) begin
                neg_off_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cyc_q <= 7'h00;
            per_q <= 7'h10;
            pos_trip_q <= 1'b0;
            neg_off_q <= 1'b0;
            prev_trip_q <= 1'b0;
        end else begin
            cyc_q <= cyc_d;
            per_q <= per_d;
            pos_trip_q <= pos_trip_d;
            neg_off_q <= neg_off_d;
            prev_trip_q <= prev_trip_d;
        end
    end

    assign limiting = pos_trip_q | prev_trip_q;

    // run state, reference ramp and protection counters
    always_comb begin
        state_d = state_q;
        ref_d = ref_q;
        lim_cnt_d = limiting ? lim_cnt_q + 17'h00001 : 17'h00000;
        hold_cnt_d = 17'h00000;
        retry_d = retry_q;
        nonsync_d = nonsync_q;
        run_d = run;
        case (state_q)
            ST_OFF: begin
                ref_d = 9'h000;
                if (run) begin
                    state_d = ST_RUN;
                    nonsync_d = prebias_i;
                end
            end
            ST_RUN: begin
                if (!run) begin
                    state_d = ST_OFF;
                    nonsync_d = 1'b0;
                end else if (lim_cnt_q >= 17'(ILIM_TIMEOUT_CYC - 1)) begin
                    state_d = ST_FAST_STOP;
                    retry_d = retry_q + 3'h1;
                end else if (step_tick && ref_q < tgt && !pos_trip_q) begin
                    // one step up, never past target
                    ref_d = (half || tgt - ref_q < 9'h002) ?
                        ref_q + 9'h001 : ref_q + 9'h002;
                end else if (step_tick && ref_q > tgt && !neg_off_q) begin
                    // discharge by the same mechanism
                    ref_d = (half || ref_q - tgt < 9'h002) ?
                        ref_q - 9'h001 : ref_q - 9'h002;
                end
                if (ref_q == tgt && !limiting) begin
                    nonsync_d = 1'b0;
                    retry_d = 3'h0;
                end
            end
            ST_FAST_STOP: begin
                ref_d = 9'h000;
                hold_cnt_d = hold_cnt_q + 17'h00001;
                if (!run) begin
                    state_d = ST_OFF;
                end else if (hold_cnt_q >= 17'(FAST_STOP_CYC - 1)) begin
                    hold_cnt_d = 17'h00000;
                    if (!pos_cmp_i) begin
                        state_d = ST_RUN;
                        nonsync_d = prebias_i;
                    end else if (retry_q >= FAST_STOP_RETRIES) begin
                        state_d = ST_LATCHED;
                    end else begin
                        retry_d = retry_q + 3'h1;
                    end
                end
            end
            ST_LATCHED: begin
                ref_d = 9'h000;
            end
            default: state_d = ST_OFF;
        endcase
        // enable edges restart both protection counters
        if (run != run_q) begin
            lim_cnt_d = 17'h00000;
            hold_cnt_d = 17'h00000;
        end
    end

    // only a supply cycle (rst_i) leaves the latched state
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_OFF;
            ref_q <= 9'h000;
            lim_cnt_q <= 17'h00000;
            hold_cnt_q <= 17'h00000;
            retry_q <= 3'h0;
            nonsync_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ref_q <= ref_d;
            lim_cnt_q <= lim_cnt_d;
            hold_cnt_q <= hold_cnt_d;
            retry_q <= retry_d;
            nonsync_q <= nonsync_d;
            run_q <= run_d;
        end
    end

    // gate drive; non-synchronous start leaves the rectifying switch of
    // the active leg off so a pre-biased output cannot be discharged
    always_comb begin
        sw = '0;
        if (state_q == ST_RUN) begin
            if (!mode_boost_i) begin
                sw.input_high_switch = on_win && !pos_trip_q;
                sw.input_low_switch = !on_win && !nonsync_q;
                sw.output_low_switch = 1'b0;
                sw.output_rectify_switch = !neg_off_q;
            end else begin
                sw.input_high_switch = !pos_trip_q;
                sw.input_low_switch = 1'b0;
                sw.output_low_switch = on_win;
                sw.output_rectify_switch = !on_win && !neg_off_q &&
                    !nonsync_q;
            end
        end
    end

    assign switches_o = sw;
    assign dac_ref_o = ref_q;
    assign pos_peak_limit_o = lim_q[LIM_POS_LSB +: 2];
    assign neg_peak_limit_o = lim_q[LIM_NEG_LSB +: 2];
    assign fast_stop_o = (state_q == ST_FAST_STOP);
    assign latched_o = (state_q == ST_LATCHED);
    assign reg_rdata_o = rdata_q;

    // checks on the ramp, limiting and protection behaviour
    property p_reset_slew;
        @(posedge sys_clk_i) disable iff (rst_i)
        $past(rst_i) |-> slew == 2'h0 && pos_peak_limit_o == 2'h0;
    endproperty
    a_reset_slew: assert property (p_reset_slew)
        else $error("slew or limit code not at reset default");
    property p_step_only_on_tick;
        @(posedge sys_clk_i) disable iff (rst_i)
        state_q == ST_RUN && run && !step_tick |=> $stable(ref_q);
    endproperty
    a_step_only_on_tick: assert property (p_step_only_on_tick)
        else $error("reference moved without a step tick");
    property p_step_size;
        @(posedge sys_clk_i) disable iff (rst_i)
        state_q == ST_RUN && run && ref_q < tgt && !pos_trip_q &&
            step_tick && lim_cnt_q < 17'(ILIM_TIMEOUT_CYC - 1)
        |=> ref_q - $past(ref_q) == (($past(half) ||
            $past(tgt) - $past(ref_q) < 9'h002) ? 9'h001 : 9'h002);
    endproperty
    a_step_size: assert property (p_step_size)
        else $error("reference step size wrong");
    property p_pos_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        state_q == ST_RUN && pos_trip_q |=> ref_q <= $past(ref_q);
    endproperty
    a_pos_hold: assert property (p_pos_hold)
        else $error("reference rose during positive limit");
    property p_neg_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        state_q == ST_RUN && neg_off_q |=> ref_q >= $past(ref_q) ||
            state_q != ST_RUN;
    endproperty
    a_neg_hold: assert property (p_neg_hold)
        else $error("reference fell during negative limit");
    property p_pos_cut;
        @(posedge sys_clk_i) disable iff (rst_i)
        pos_trip_q |-> !switches_o.input_high_switch;
    endproperty
    a_pos_cut: assert property (p_pos_cut)
        else $error("input high switch on after positive trip");
    property p_timeout;
        @(posedge sys_clk_i) disable iff (rst_i)
        state_q == ST_RUN && run && run_q &&
            lim_cnt_q == 17'(ILIM_TIMEOUT_CYC - 1)
        |=> state_q == ST_FAST_STOP ##1 switches_o == '0;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("limit timeout did not enter fast stop");
    property p_fast_off;
        @(posedge sys_clk_i) disable iff (rst_i)
        state_q == ST_FAST_STOP || state_q == ST_LATCHED |->
            switches_o == '0;
    endproperty
    a_fast_off: assert property (p_fast_off)
        else $error("switch driven during fast stop");
    property p_latched;
        @(posedge sys_clk_i) disable iff (rst_i)
        state_q == ST_LATCHED |=> state_q == ST_LATCHED [*3];
    endproperty
    a_latched: assert property (p_latched)
        else $error("latched shutdown left without reset");
    property p_nonsync;
        @(posedge sys_clk_i) disable iff (rst_i)
        state_q == ST_RUN && nonsync_q |-> !switches_o.input_low_switch &&
            (!mode_boost_i || !switches_o.output_rectify_switch);
    endproperty
    a_nonsync: assert property (p_nonsync)
        else $error("synchronous switch on during pre-bias start");
endmodule

/* File: hw/bbrc_pkg.sv */
// shared constants, types and helpers of the buck-boost ramp and limit core
package bbrc_pkg;
    // register offsets
    localparam logic [7:0] REG_ENABLE = 8'h00;
    localparam logic [7:0] REG_PROFILE = 8'h01;
    localparam logic [7:0] REG_LIMITS = 8'h02;
    localparam logic [7:0] REG_CONFIG = 8'h03;
    localparam logic [7:0] REG_SENSE_A = 8'h04;
    localparam logic [7:0] REG_SENSE_B = 8'h05;
    localparam logic [7:0] REG_STATUS = 8'h06;
    // field positions
    localparam int CFG_FREQ_LSB = 0;
    localparam int CFG_HALF_BIT = 4;
    localparam int LIM_SLEW_LSB = 0;
    localparam int LIM_POS_LSB = 2;
    localparam int LIM_NEG_LSB = 4;
    // reset values
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] PROFILE_RST = 8'h32;
    localparam logic [7:0] LIMITS_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    // clock and ramp timing
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PER_US = CLK_HZ / 1_000_000;
    localparam int SLOW_RATE_UV_PER_US = 600;
    localparam int STEP_FULL_UV = 10_000;
    localparam int STEP_HALF_UV = 5_000;
    // protection timing
    localparam int ILIM_TIMEOUT_MS = 2;
    localparam int FAST_STOP_MS = 10;
    localparam int ILIM_TIMEOUT_CYC_DEF = ILIM_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int FAST_STOP_CYC_DEF = FAST_STOP_MS * (CLK_HZ / 1000);
    localparam logic [2:0] FAST_STOP_RETRIES = 3'h4;
    // switching frequencies in kHz
    localparam int FREQ_KHZ_0 = 600;
    localparam int FREQ_KHZ_1 = 150;
    localparam int FREQ_KHZ_2 = 300;
    localparam int FREQ_KHZ_3 = 450;
    localparam int FREQ_KHZ_4 = 750;
    localparam int FREQ_KHZ_5 = 900;
    localparam int FREQ_KHZ_6 = 1200;

    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_FAST_STOP, ST_LATCHED}
        bbrc_state_t;

    typedef struct packed {
        logic input_high_switch;
        logic input_low_switch;
        logic output_low_switch;
        logic output_rectify_switch;
    } bbrc_switch_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bbrc_reg_req_t;

    // clocks per reference step, rounded up so the rate never exceeds the code
    function automatic logic [7:0] step_cycles(input logic [1:0] slew,
                                               input logic half);
        int rate;
        int uv;
        rate = SLOW_RATE_UV_PER_US << slew;
        uv = half ? STEP_HALF_UV : STEP_FULL_UV;
        return 8'((uv * CLK_PER_US + rate - 1) / rate);
    endfunction

    // switching period in clocks, rounded down; reserved code keeps 600 kHz
    function automatic logic [6:0] switch_period(input logic [2:0] code);
        int khz;
        case (code)
            3'h1: khz = FREQ_KHZ_1;
            3'h2: khz = FREQ_KHZ_2;
            3'h3: khz = FREQ_KHZ_3;
            3'h4: khz = FREQ_KHZ_4;
            3'h5: khz = FREQ_KHZ_5;
            3'h6: khz = FREQ_KHZ_6;
            default: khz = FREQ_KHZ_0;
        endcase
        return 7'(CLK_HZ / (khz * 1000));
    endfunction
endpackage

/* File: hw/bbrc_step_gen.sv */
// step clock divider: one-cycle enable per reference step
`timescale 1ns/100ps
module bbrc_step_gen import bbrc_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [1:0] slew_i,
    input wire logic half_i,
    output logic tick_o
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] period;

    // slower code gives a longer count between steps
    always_comb begin
        period = step_cycles(slew_i, half_i);
        cnt_d = cnt_q + 8'h01;
        tick_o = 1'b0;
        if (!run_i) begin
            cnt_d = 8'h00;
        end else if (cnt_q >= period - 8'h01) begin
            cnt_d = 8'h00;
            tick_o = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
